// *** shared/backplane_pkg.sv ***
// shared types and timing constants for the backplane transfer master
// assumes a 20 MHz system clock; all bus lines are active low, open collector
package backplane_pkg;

   //***************************************************************
   // widths and timing
   //***************************************************************
   localparam int ADDR_W          = 22;
   localparam int DATA_W          = 16;
   localparam int RD_W            = 18;     // data plus the two parity lines
   localparam int IO_ADDR_BITS    = 13;     // low bits decoded inside the I/O page
   localparam int CLK_PERIOD_NS   = 50;
   localparam int ADDR_SETUP_NS   = 75;
   localparam int STROBE_DELAY_NS = 100;
   localparam int REPLY_DESKEW_NS = 200;
   localparam int DOUT_HOLD_NS    = 150;
   localparam int SYNC_AFTER_NS   = 175;
   localparam int RMW_GAP_NS      = 200;
   localparam int SYNC_IDLE_NS    = 300;
   localparam int TIMEOUT_NS      = 10000;
   // least times round up, the timeout (a longest time) rounds down
   localparam int ADDR_SETUP_CYC   = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REPLY_DESKEW_CYC = (REPLY_DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DOUT_HOLD_CYC    = (DOUT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_AFTER_CYC   = (SYNC_AFTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RMW_GAP_CYC      = (RMW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_IDLE_CYC    = (SYNC_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMEOUT_CYC      = TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int CNT_W            = 4;
   localparam int TMO_W            = 8;
   localparam int WORDS_W          = 8;

   //***************************************************************
   // types
   //***************************************************************
   typedef enum logic [2:0] {
      WORD_READ, WORD_WRITE, BYTE_WRITE, RMW_WORD, RMW_BYTE, BLOCK_READ, BLOCK_WRITE
   } cycle_kind_t;

   typedef struct packed {
      cycle_kind_t             kind;
      logic [ADDR_W-1:0]       addr;
      logic                    ioPage;
      logic [WORDS_W-1:0]      words;   // block length, 0 and 1 both mean one word
   } cmd_t;

   // enables of the open-collector control drivers, high pulls the line low
   typedef struct packed {
      logic cycleFrame;
      logic readData;
      logic writeData;
      logic writeByte;
      logic ioPageSel;
   } ctrl_oe_t;

endpackage : backplane_pkg

// *** verif/backplane_master_test.sv ***
// self-checking bench for the backplane master against the slave model
// assumes a 20 MHz clock; the bench resolves every open-collector line
`timescale 1ns/1ps
`default_nettype none
module backplane_master_test
   import backplane_pkg::*;
;
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   logic              cmdValid = 1'b0;
   logic              cmdReady;
   cmd_t              cmd = '0;
   logic              wrValid = 1'b0;
   logic              wrReady;
   logic [DATA_W-1:0] wrData = 16'h0000;
   logic              rdValid;
   logic              rdReady = 1'b1;
   logic [RD_W-1:0]   rdData;
   logic              doneValid;
   logic              doneErr;
   ctrl_oe_t          ctrlOe;
   logic              replyOe;
   logic [ADDR_W-1:0] mDalOutN;
   logic              mDalOe;
   logic [ADDR_W-1:0] sDalOutN;
   logic              sDalOe;
   logic [ADDR_W-1:0] dalN;
   logic              replyLineN;
   logic              syncLineN;
   logic              dinLineN;
   logic              doutLineN;
   logic              wtbtLineN;
   logic              bs7LineN;
   logic [7:0]        replyDelay = 8'h03;
   logic              mute = 1'b0;
   logic              rdHold = 1'b0;
   logic [DATA_W-1:0] wrQ [$];
   logic [RD_W-1:0]   rdQ [$];
   int                n_fail = 0;
   int                tests_run = 0;

   always #25 clk = ~clk;
   assign dalN = (mDalOe ? mDalOutN : '1) & (sDalOe ? sDalOutN : '1);
   // control lines read high unless a driver pulls them low
   assign replyLineN = ~replyOe;
   assign syncLineN  = ~ctrlOe.cycleFrame;
   assign dinLineN   = ~ctrlOe.readData;
   assign doutLineN  = ~ctrlOe.writeData;
   assign wtbtLineN  = ~ctrlOe.writeByte;
   assign bs7LineN   = ~ctrlOe.ioPageSel;

   backplane_master #(.FIFO_DEPTH(8)) u_backplane_master (
      .clk(clk), .srst(srst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
      .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid),
      .rdReady(rdReady), .rdData(rdData), .doneValid(doneValid), .doneErr(doneErr),
      .ctrlOe(ctrlOe), .slaveReplyInN(replyLineN), .dalInN(dalN), .dalOutN(mDalOutN),
      .dalOe(mDalOe));
   backplane_slave_model u_backplane_slave_model (
      .clk(clk), .syncN(syncLineN), .dinN(dinLineN),
      .doutN(doutLineN), .wtbtN(wtbtLineN), .bs7N(bs7LineN),
      .dalN(dalN), .replyDelay(replyDelay), .mute(mute), .replyOe(replyOe),
      .dalOe(sDalOe), .dalOutN(sDalOutN));

   //******************************
   // drivers, monitor and checks
   //******************************
   // write-word feeder and read-word collector, both stepping just after the edge
   always @(posedge clk) begin
      if (wrValid && wrReady) void'(wrQ.pop_front());
      if (rdValid && rdReady) rdQ.push_back(rdData);
      #1;
      wrValid = (wrQ.size() > 0);
      wrData = (wrQ.size() > 0) ? wrQ[0] : 16'h0000;
      rdReady = !rdHold;
   end

   // strobes only inside a frame, never both at once
   always @(posedge clk) begin
      if (!srst && (ctrlOe.readData || ctrlOe.writeData) && !ctrlOe.cycleFrame) fail("strobe out of frame");
      if (!srst && ctrlOe.readData && ctrlOe.writeData) fail("both strobes");
   end

   task automatic fail(input string msg);
      n_fail++;
      $display("ERROR at %0t: %s", $time, msg);
   endtask : fail

   task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp, input string msg);
      tests_run++;
      if (got !== exp) fail($sformatf("%s got %h expected %h", msg, got, exp));
   endtask : chk

   // offer one command, wait for it to be taken and for its end pulse
   task automatic doCmd(input cycle_kind_t kind, input logic [ADDR_W-1:0] addr,
                        input logic io, input logic [7:0] words, input logic expErr);
      int i;
      @(posedge clk);
      #1;
      cmdValid = 1'b1;
      cmd = '{kind, addr, io, words};
      i = 0;
      do begin @(posedge clk); i++; end while (cmdReady !== 1'b1 && i < 40);
      #1;
      cmdValid = 1'b0;
      i = 0;
      do begin @(posedge clk); i++; end while (doneValid !== 1'b1 && i < 3000);
      tests_run++;
      if (doneValid !== 1'b1 || doneErr !== expErr) fail("cycle end or error flag wrong");
      #1;
   endtask : doCmd

   task automatic expRd(input logic [DATA_W-1:0] exp);
      if (rdQ.size() == 0) fail("read word missing");
      else chk(22'(rdQ.pop_front()), {6'h00, exp}, "read data");
   endtask : expRd

   // word write then read at an address using all upper lines
   task automatic t_word;
      wrQ.push_back(16'hA55A);
      doCmd(WORD_WRITE, 22'h3F0010, 1'b0, 8'h01, 1'b0);
      chk(u_backplane_slave_model.addr, 22'h3F0010, "latched address");
      chk(22'(u_backplane_slave_model.wrCyc), 22'h1, "write flag");
      chk(22'(u_backplane_slave_model.mem[8]), 22'h00A55A, "word stored");
      doCmd(WORD_READ, 22'h3F0010, 1'b0, 8'h01, 1'b0);
      chk(22'(u_backplane_slave_model.wrCyc), 22'h0, "read flag");
      chk(22'(u_backplane_slave_model.ioCyc), 22'h0, "memory space");
      expRd(16'hA55A);
   endtask : t_word

   // high byte write, then read back the merged word
   task automatic t_byte;
      wrQ.push_back(16'hC300);
      doCmd(BYTE_WRITE, 22'h000011, 1'b0, 8'h01, 1'b0);
      doCmd(WORD_READ, 22'h000010, 1'b0, 8'h01, 1'b0);
      expRd(16'hC35A);
   endtask : t_byte

   // read-modify-write in word and low-byte form
   task automatic t_rmw;
      wrQ.push_back(16'h1234);
      doCmd(RMW_WORD, 22'h000010, 1'b0, 8'h01, 1'b0);
      expRd(16'hC35A);
      chk(22'(u_backplane_slave_model.mem[8]), 22'h001234, "rmw word");
      wrQ.push_back(16'h0077);
      doCmd(RMW_BYTE, 22'h000010, 1'b0, 8'h01, 1'b0);
      expRd(16'h1234);
      chk(22'(u_backplane_slave_model.mem[8]), 22'h001277, "rmw byte");
   endtask : t_rmw

   // three words out and back under one address each way
   task automatic t_block;
      for (int i = 1; i <= 3; i++) wrQ.push_back(16'(16'h1111 * i));
      doCmd(BLOCK_WRITE, 22'h000020, 1'b0, 8'h03, 1'b0);
      for (int i = 0; i < 3; i++) chk(22'(u_backplane_slave_model.mem[16+i]), 22'(16'h1111 * (i + 1)), "block stored");
      doCmd(BLOCK_READ, 22'h000020, 1'b0, 8'h03, 1'b0);
      for (int i = 1; i <= 3; i++) expRd(16'(16'h1111 * i));
   endtask : t_block

   // io-page write reaches the device through the low bits
   task automatic t_io;
      wrQ.push_back(16'h0F0F);
      doCmd(WORD_WRITE, 22'h3FE004, 1'b1, 8'h01, 1'b0);
      chk(22'(u_backplane_slave_model.ioCyc), 22'h1, "io select");
      chk(22'(u_backplane_slave_model.mem[2]), 22'h000F0F, "io word");
   endtask : t_io

   // ten-word block read with the reader stalled until the buffer is full
   task automatic t_fifo;
      for (int i = 0; i < 10; i++) u_backplane_slave_model.mem[32+i] = 16'(16'h0100 + i);
      rdHold = 1'b1;
      fork
         doCmd(BLOCK_READ, 22'h000040, 1'b0, 8'h0A, 1'b0);
         begin
            repeat (250) @(posedge clk);
            #1;
            chk(22'(rdQ.size()), 22'h0, "nothing drained");
            chk(22'(ctrlOe.readData), 22'h0, "stalled when full");
            chk(22'(ctrlOe.cycleFrame), 22'h1, "frame held");
            rdHold = 1'b0;
         end
      join
      for (int i = 0; i < 10; i++) expRd(16'(16'h0100 + i));
      chk(22'(rdQ.size()), 22'h0, "no extra words");
   endtask : t_fifo

   // slow reply, then silence, then recovery
   task automatic t_slow;
      replyDelay = 8'd60;
      doCmd(WORD_READ, 22'h000010, 1'b0, 8'h01, 1'b0);
      expRd(16'h1277);
      replyDelay = 8'h03;
      mute = 1'b1;
      doCmd(WORD_READ, 22'h000010, 1'b0, 8'h01, 1'b1);
      chk(22'(ctrlOe), 22'h0, "lines released");
      chk(22'(rdQ.size()), 22'h0, "no word on abort");
      mute = 1'b0;
      doCmd(WORD_READ, 22'h000010, 1'b0, 8'h01, 1'b0);
      expRd(16'h1277);
   endtask : t_slow

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   initial begin
      repeat (5) @(posedge clk);
      #1;
      srst = 1'b0;
      t_word();
      t_byte();
      t_rmw();
      t_block();
      t_io();
      t_fifo();
      t_slow();
      test_done();
   end

   // watchdog well beyond the expected thousand or so cycles
   initial begin
      #2000000;
      fail("watchdog expired");
      test_done();
   end
endmodule : backplane_master_test
`default_nettype wire

// *** verif/backplane_slave_model.sv ***
// slave device model for the backplane master: 64-word memory, adjustable reply delay
// assumes the bench resolves open-collector lines, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module backplane_slave_model
   import backplane_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              syncN,
   input  wire logic              dinN,
   input  wire logic              doutN,
   input  wire logic              wtbtN,
   input  wire logic              bs7N,
   input  wire logic [ADDR_W-1:0] dalN,
   input  wire logic [7:0]        replyDelay,
   input  wire logic              mute,
   output logic                   replyOe = 1'b0,
   output logic                   dalOe = 1'b0,
   output logic      [ADDR_W-1:0] dalOutN = '1
);
   logic [15:0]       mem [0:63];
   logic [ADDR_W-1:0] addr;
   logic              wrCyc;
   logic              ioCyc;
   logic              syncPrev = 1'b1;
   logic              pend = 1'b0;
   logic              lastIn = 1'b0;
   logic [7:0]        cnt = 8'h00;
   logic [5:0]        idx;

   // both spaces decode low address bits only, so io-page upper bits never matter
   assign idx = addr[6:1];

   //******************************
   // transfer engine
   //******************************
   // latch selection at frame start, answer each strobe after a delay, release on negation
   always @(posedge clk) begin
      syncPrev <= syncN;
      if (syncN) begin
         replyOe <= 1'b0;
         dalOe   <= 1'b0;
         dalOutN <= '1;
         cnt     <= 8'h00;
         pend    <= 1'b0;
      end else if (syncPrev) begin
         addr  <= ~dalN;
         ioCyc <= ~bs7N;
         wrCyc <= ~wtbtN;
      end else if (replyOe) begin
         if (dinN && doutN) begin
            replyOe <= 1'b0;
            dalOe   <= 1'b0;
            dalOutN <= '1;
            cnt     <= 8'h00;
            pend    <= 1'b1;
         end
      end else if (!(dinN && doutN) && !mute) begin
         // a second strobe in the same direction moves on to the next word
         if (cnt == 8'h00 && pend && lastIn == !dinN) addr <= addr + 22'h000002;
         pend <= 1'b0;
         if (cnt < replyDelay) cnt <= cnt + 8'h01;
         else begin
            replyOe <= 1'b1;
            lastIn  <= !dinN;
            if (!dinN) begin
               dalOe   <= 1'b1;
               dalOutN <= {6'h3F, ~mem[idx]};
            end
            else if (wtbtN) mem[idx] <= ~dalN[15:0];
            else if (addr[0]) mem[idx][15:8] <= ~dalN[15:8];
            else mem[idx][7:0] <= ~dalN[7:0];
         end
      end
   end
endmodule : backplane_slave_model
`default_nettype wire

// *** verilog/backplane_master.sv ***
// transfer-cycle master for the asynchronous multiplexed backplane, with read fifo
// assumes one 20 MHz clock, synchronous reset, and a testbench that resolves the
// open-collector wires from the enables (line low while any enable is high)
`timescale 1ns/1ps
`default_nettype none

//***************************************************************
// synchronous fifo
//***************************************************************
module sync_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wrPtr_r;
   logic [PW:0]      rdPtr_r;

   // full when pointers differ only in the wrap bit
   assign inReady  = !((wrPtr_r[PW] != rdPtr_r[PW]) && (wrPtr_r[PW-1:0] == rdPtr_r[PW-1:0]));
   assign outValid = (wrPtr_r != rdPtr_r);
   assign outData  = mem[rdPtr_r[PW-1:0]];

   // write side
   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_r <= '0;
      end else if (inValid && inReady) begin
         mem[wrPtr_r[PW-1:0]] <= inData;
         wrPtr_r              <= wrPtr_r + 1'b1;
      end
   end

   // read side
   always_ff @(posedge clk) begin
      if (srst) begin
         rdPtr_r <= '0;
      end else if (outValid && outReady) begin
         rdPtr_r <= rdPtr_r + 1'b1;
      end
   end
endmodule : sync_fifo

//***************************************************************
// bus master
//***************************************************************
module backplane_master
   import backplane_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              cmdValid,
   output logic                   cmdReady,
   input  wire cmd_t              cmd,
   input  wire logic              wrValid,
   output logic                   wrReady,
   input  wire logic [DATA_W-1:0] wrData,
   output logic                   rdValid,
   input  wire logic              rdReady,
   output logic      [RD_W-1:0]   rdData,
   output logic                   doneValid,
   output logic                   doneErr,
   output ctrl_oe_t               ctrlOe,
   input  wire logic              slaveReplyInN,
   input  wire logic [ADDR_W-1:0] dalInN,
   output logic      [ADDR_W-1:0] dalOutN,
   output logic                   dalOe
);
   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AHOLD, S_DATA, S_RD_WAIT, S_RD_DESKEW, S_RD_END,
      S_WR_SETUP, S_WR_WAIT, S_WR_HOLD, S_WR_END, S_GAP, S_ABORT, S_RECOVER
   } state_t;

   state_t              state_r, state_nxt;
   logic [CNT_W-1:0]    cnt_r, cnt_nxt;
   logic [TMO_W-1:0]    tmo_r;
   cmd_t                cmd_r;
   logic                rmwOut_r;
   logic [DATA_W-1:0]   wdat_r;
   logic                replyMeta_r, replySync_r;
   logic [ADDR_W-1:0]   dalMeta_r, dalSync_r;
   logic                replyAct, readPhase, writeKind, byteOut, moreWords, tmoHit;
   logic                fifoInReady, push;
   ctrl_oe_t            ctrlOe_r;
   logic [ADDR_W-1:0]   dalOutN_r;
   logic                dalOe_r, doneValid_r, doneErr_r;

   //***************************************************************
   // pin synchronisers
   //***************************************************************
   // second flop only is read by logic
   always_ff @(posedge clk) begin
      if (srst) begin
         replyMeta_r <= 1'b1;
         replySync_r <= 1'b1;
         dalMeta_r   <= '1;
         dalSync_r   <= '1;
      end else begin
         replyMeta_r <= slaveReplyInN;
         replySync_r <= replyMeta_r;
         dalMeta_r   <= dalInN;
         dalSync_r   <= dalMeta_r;
      end
   end
   assign replyAct = !replySync_r;

   // cycle decode of the latched command
   assign writeKind = (cmd_r.kind == WORD_WRITE) || (cmd_r.kind == BYTE_WRITE)
                   || (cmd_r.kind == BLOCK_WRITE);
   assign readPhase = !writeKind && !rmwOut_r;
   assign byteOut   = (cmd_r.kind == BYTE_WRITE) || (cmd_r.kind == RMW_BYTE);
   assign moreWords = ((cmd_r.kind == BLOCK_READ) || (cmd_r.kind == BLOCK_WRITE))
                   && (cmd_r.words > 8'h01);
   assign tmoHit    = (tmo_r == TMO_W'(TIMEOUT_CYC));
   assign push      = (state_r == S_RD_DESKEW) && (cnt_r == 4'h1);
   assign cmdReady  = (state_r == S_IDLE);
   assign wrReady   = (state_r == S_DATA) && !readPhase;

   //***************************************************************
   // sequencer
   //***************************************************************
   // next state and interval count
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      unique case (state_r)
         S_IDLE: if (cmdValid) begin
            state_nxt = S_ADDR;
            cnt_nxt   = CNT_W'(ADDR_SETUP_CYC);
         end
         // address lines take the latched command one edge after the take, so count to zero
         S_ADDR: if (cnt_r == 4'h0) begin
            state_nxt = S_AHOLD;
            cnt_nxt   = CNT_W'(STROBE_DELAY_CYC);
         end
         S_AHOLD, S_GAP: if (cnt_r <= 4'h1) state_nxt = S_DATA;
         S_DATA: begin
            if (readPhase && fifoInReady) begin
               state_nxt = S_RD_WAIT;          // stalls while the fifo is full
            end else if (!readPhase && wrValid) begin
               state_nxt = S_WR_SETUP;
               cnt_nxt   = CNT_W'(STROBE_DELAY_CYC);
            end
         end
         S_RD_WAIT: begin
            if (replyAct) begin
               state_nxt = S_RD_DESKEW;
               cnt_nxt   = CNT_W'(REPLY_DESKEW_CYC);
            end else if (tmoHit) begin
               state_nxt = S_ABORT;
            end
         end
         S_RD_DESKEW: if (cnt_r == 4'h1) state_nxt = S_RD_END;
         S_RD_END: begin
            if (!replyAct) begin
               cnt_nxt = CNT_W'(RMW_GAP_CYC);
               if ((cmd_r.kind == RMW_WORD) || (cmd_r.kind == RMW_BYTE) || moreWords) begin
                  state_nxt = S_GAP;
               end else begin
                  state_nxt = S_RECOVER;
                  cnt_nxt   = CNT_W'(SYNC_IDLE_CYC);
               end
            end else if (tmoHit) begin
               state_nxt = S_ABORT;
            end
         end
         // data lines take the write data register one edge after the take, so count to zero
         S_WR_SETUP: if (cnt_r == 4'h0) state_nxt = S_WR_WAIT;
         S_WR_WAIT: begin
            if (replyAct) begin
               state_nxt = S_WR_HOLD;
               cnt_nxt   = CNT_W'(DOUT_HOLD_CYC);
            end else if (tmoHit) begin
               state_nxt = S_ABORT;
            end
         end
         S_WR_HOLD: if (cnt_r == 4'h1) begin
            state_nxt = S_WR_END;
            cnt_nxt   = CNT_W'(SYNC_AFTER_CYC);
         end
         S_WR_END: begin
            if (!replyAct && (cnt_r <= 4'h1)) begin
               state_nxt = moreWords ? S_GAP : S_RECOVER;
               cnt_nxt   = moreWords ? CNT_W'(RMW_GAP_CYC) : CNT_W'(SYNC_IDLE_CYC);
            end else if (tmoHit) begin
               state_nxt = S_ABORT;
            end
         end
         S_ABORT: begin
            state_nxt = S_RECOVER;
            cnt_nxt   = CNT_W'(SYNC_IDLE_CYC);
         end
         S_RECOVER: if (cnt_r <= 4'h1) state_nxt = S_IDLE;
      endcase
   end

   // state and interval counter
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= S_IDLE;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // reply timeout, restarted whenever a wait for the slave begins
   always_ff @(posedge clk) begin
      if (srst || (state_nxt != state_r)) begin
         tmo_r <= '0;
      end else if ((state_r == S_RD_WAIT) || (state_r == S_RD_END)
                || (state_r == S_WR_WAIT) || (state_r == S_WR_END)) begin
         tmo_r <= tmo_r + 1'b1;
      end
   end

   // command latch, block word count and read-modify-write phase
   always_ff @(posedge clk) begin
      if (srst) begin
         cmd_r    <= '0;
         rmwOut_r <= 1'b0;
      end else if (state_r == S_IDLE && cmdValid) begin
         cmd_r    <= cmd;
         rmwOut_r <= 1'b0;
      end else if (state_nxt == S_GAP && state_r != S_GAP) begin
         if (moreWords) cmd_r.words <= cmd_r.words - 1'b1;
         else rmwOut_r <= 1'b1;                // output half follows, frame kept
      end
   end

   // write data capture
   always_ff @(posedge clk) begin
      if (srst) wdat_r <= '0;
      else if (wrValid && wrReady) wdat_r <= wrData;
   end

   //***************************************************************
   // bus drivers, registered from the next state
   //***************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrlOe_r  <= '0;
         dalOe_r   <= 1'b0;
         dalOutN_r <= '1;
      end else begin
         ctrlOe_r.cycleFrame <= !(state_nxt inside {S_IDLE, S_ADDR, S_ABORT, S_RECOVER});
         ctrlOe_r.readData   <= (state_nxt == S_RD_WAIT) || (state_nxt == S_RD_DESKEW);
         ctrlOe_r.writeData  <= (state_nxt == S_WR_WAIT) || (state_nxt == S_WR_HOLD);
         ctrlOe_r.ioPageSel  <= (state_nxt == S_ADDR || state_nxt == S_AHOLD)
                             && cmd_r.ioPage;
         ctrlOe_r.writeByte  <= ((state_nxt == S_ADDR || state_nxt == S_AHOLD) && writeKind)
                             || ((state_nxt inside {S_WR_SETUP, S_WR_WAIT, S_WR_HOLD, S_WR_END})
                                 && byteOut);
         // address on all 22 lines, data on the low 16 only, inverted for low-true
         if (state_nxt == S_ADDR || state_nxt == S_AHOLD) begin
            dalOe_r   <= 1'b1;
            dalOutN_r <= ~cmd_r.addr;
         end else if (state_nxt inside {S_WR_SETUP, S_WR_WAIT, S_WR_HOLD, S_WR_END}) begin
            dalOe_r   <= 1'b1;
            dalOutN_r <= {6'h3F, ~wdat_r};
         end else begin
            dalOe_r   <= 1'b0;
            dalOutN_r <= '1;
         end
      end
   end
   assign ctrlOe  = ctrlOe_r;
   assign dalOe   = dalOe_r;
   assign dalOutN = dalOutN_r;

   // completion pulse, error on timeout
   always_ff @(posedge clk) begin
      if (srst) begin
         doneValid_r <= 1'b0;
         doneErr_r   <= 1'b0;
      end else begin
         doneValid_r <= (state_nxt == S_RECOVER) && (state_r != S_RECOVER);
         doneErr_r   <= (state_r == S_ABORT);
      end
   end
   assign doneValid = doneValid_r;
   assign doneErr   = doneErr_r;

   //***************************************************************
   // read data fifo, parity lines kept with the word
   //***************************************************************
   sync_fifo #(.WIDTH(RD_W), .DEPTH(FIFO_DEPTH)) readFifo (
      .clk      (clk),
      .srst     (srst),
      .inValid  (push),
      .inReady  (fifoInReady),
      .inData   (~dalSync_r[RD_W-1:0]),
      .outValid (rdValid),
      .outReady (rdReady),
      .outData  (rdData)
   );

   //***************************************************************
   // checks
   //***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   strobe_in_frame_a:  assert property ((ctrlOe.readData || ctrlOe.writeData) |-> ctrlOe.cycleFrame)
      else $error("data strobe outside frame");
   strobes_apart_a:    assert property (!(ctrlOe.readData && ctrlOe.writeData))
      else $error("both data strobes asserted");
   timeout_bound_a:    assert property (tmo_r <= TMO_W'(TIMEOUT_CYC))
      else $error("reply wait beyond timeout");
   abort_on_tmo_a:     assert property (tmoHit && !replyAct && state_r == S_RD_WAIT
                                        |=> ##1 !ctrlOe.cycleFrame && !ctrlOe.readData)
      else $error("timeout did not abort");
   dir_at_frame_a:     assert property ($rose(ctrlOe.cycleFrame) |-> ctrlOe.writeByte == writeKind)
      else $error("write/byte wrong at frame");
   iopage_at_frame_a:  assert property ($rose(ctrlOe.cycleFrame) |-> ctrlOe.ioPageSel == cmd_r.ioPage)
      else $error("io page select wrong");
   addr_at_frame_a:    assert property ($rose(ctrlOe.cycleFrame)
                                        |-> dalOe && dalOutN == ~cmd_r.addr && $past(dalOe, 2)
                                            && $past(dalOutN, 2) == dalOutN)
      else $error("address not set up at frame");
   reply_synced_a:     assert property (replyAct == !$past(slaveReplyInN, 2))
      else $error("reply not two-stage synced");
   byte_mark_a:        assert property (ctrlOe.writeData && byteOut |-> ctrlOe.writeByte)
      else $error("byte output not marked");
   data_low_lines_a:   assert property (ctrlOe.writeData |-> dalOutN[ADDR_W-1:DATA_W] == 6'h3F)
      else $error("upper lines driven in data");
   wdata_setup_a:      assert property ($rose(ctrlOe.writeData) |-> $past(dalOutN, 2) == dalOutN)
      else $error("write data not set up");
   deskew_hold_a:      assert property (state_r == S_RD_WAIT && replyAct |=> ctrlOe.readData [*4])
      else $error("read strobe released early");

   read_done_c:  cover property (doneValid && !doneErr && cmd_r.kind == WORD_READ);
   block_wr_c:   cover property (state_r == S_GAP && cmd_r.kind == BLOCK_WRITE);
   rmw_c:        cover property (rmwOut_r && ctrlOe.writeData);
   abort_c:      cover property (doneValid && doneErr);
endmodule : backplane_master

`default_nettype wire
